// [verilog/lds_mode_seq.sv]
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lds_map.svh"
module lds_mode_seq
  import lds_pkg::*;
#(
  parameter int STARTUP_CYCLES = `LDS_STARTUP_US * `LDS_CLK_MHZ
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Avalon-MM register port.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device pins and monitors.
  input wire logic por_i,
  input wire logic en_i,
  input wire logic overheat_shutdown_i,
  // Mode and power controls.
  output logic [2:0] mode_o,
  output logic circuits_en_o,
  output logic analog_en_o,
  output logic [7:0] user_ctrl_o
);
  localparam int AW = $clog2(STARTUP_CYCLES + 1);

  lds_reg_if reg_if (); // Strobes from the bus slave.
  lds_seq_st_t st; // Registered sequencer state.
  lds_seq_st_t next_st; // Next sequencer state.
  logic soft_rst; // Software reset write seen this cycle.
  logic wr_ok; // Register write that is accepted.
  logic tmr_start; // Startup delay begins.
  logic tmr_clear; // Startup delay abandoned.
  logic tmr_done; // Startup delay has run out.
  logic run; // Stored run bit.
  logic psave; // Stored power save request.
  logic [7:0] status; // Status register image.

  // The delay counter must be able to count at least two cycles.
  if (STARTUP_CYCLES < 2) begin : g_bad_startup
    $error("STARTUP_CYCLES must be at least 2");
  end

  // Bus slave; every access takes one wait cycle.
  lds_avmm_slave u_bus (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .reg_if(reg_if)
  );

  // Startup delay timer on the system clock.
  lds_delay_timer #(
    .CYCLES(STARTUP_CYCLES)
  ) u_tmr (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .start_i(tmr_start),
    .clear_i(tmr_clear),
    .done_o(tmr_done)
  );

  assign run = st.ctrl[`LDS_CTRL_RUN_BIT];
  assign psave = st.ctrl[`LDS_CTRL_PSAVE_BIT];

  // Write decode. The enable pin gates all writes, so software cannot set
  // the run bit in the same cycle in which hardware clears it.
  always_comb begin
    soft_rst = reg_if.wr_stb && en_i && (reg_if.wr_idx == `LDS_IDX_SOFT_RESET)
               && (reg_if.wr_data == `LDS_SOFT_RESET_KEY);
    wr_ok = reg_if.wr_stb && en_i;
  end

  // Status image and read multiplexer; unmapped and write-only read zero.
  always_comb begin
    status = 8'h00;
    status[`LDS_STAT_MODE_LSB +: 3] = st.mode;
    status[`LDS_STAT_DONE_BIT] = tmr_done;
    status[`LDS_STAT_HOT_BIT] = overheat_shutdown_i;
    status[`LDS_STAT_EN_BIT] = en_i;
    unique case (reg_if.rd_idx)
      `LDS_IDX_CTRL: begin
        reg_if.rd_data = st.ctrl;
      end
      `LDS_IDX_USER: begin
        reg_if.rd_data = st.user;
      end
      `LDS_IDX_STATUS: begin
        reg_if.rd_data = status;
      end
      default: begin
        reg_if.rd_data = 8'h00;
      end
    endcase
  end

  // Mode sequencer and register file.
  always_comb begin
    next_st = st;
    if (por_i || soft_rst) begin
      // Supply low or software reset: everything back to defaults.
      next_st.mode = LDS_RESET;
      next_st.ctrl = `LDS_CTRL_RST;
      next_st.user = `LDS_USER_RST;
    end else begin
      // Writes are stored in any mode; the user byte acts only later.
      if (wr_ok && reg_if.wr_idx == `LDS_IDX_CTRL) begin
        next_st.ctrl = reg_if.wr_data;
      end
      if (wr_ok && reg_if.wr_idx == `LDS_IDX_USER) begin
        next_st.user = reg_if.wr_data;
      end
      unique case (st.mode)
        LDS_RESET: begin
          next_st.mode = LDS_STANDBY;
        end
        LDS_STANDBY: begin
          // Decided on the stored bit, so a new run write acts a cycle later.
          if (run && en_i) begin
            next_st.mode = LDS_STARTUP;
          end
        end
        LDS_STARTUP: begin
          if (!run || !en_i) begin
            next_st.mode = LDS_STANDBY;
          end else if (tmr_done && !overheat_shutdown_i) begin
            next_st.mode = LDS_NORMAL;
          end
          // Otherwise stay here while the delay runs or overheat lasts.
        end
        LDS_NORMAL, LDS_PSAVE: begin
          if (!en_i) begin
            next_st.ctrl[`LDS_CTRL_RUN_BIT] = 1'b0;
            next_st.mode = LDS_STANDBY;
          end else if (!run) begin
            next_st.mode = LDS_STANDBY;
          end else if (overheat_shutdown_i) begin
            // The delay stays expired, so recovery is immediate on cool-down.
            next_st.mode = LDS_STARTUP;
          end else if (psave) begin
            next_st.mode = LDS_PSAVE;
          end else begin
            next_st.mode = LDS_NORMAL;
          end
        end
        default: begin
          next_st.mode = LDS_RESET;
        end
      endcase
    end
    // Power controls follow the mode that is about to be entered.
    next_st.circ_en = (next_st.mode == LDS_STARTUP) || (next_st.mode == LDS_NORMAL)
                      || (next_st.mode == LDS_PSAVE);
    next_st.analog_en = ((next_st.mode == LDS_STARTUP) || (next_st.mode == LDS_NORMAL))
                        && !overheat_shutdown_i;
    if (next_st.mode == LDS_NORMAL || next_st.mode == LDS_PSAVE) begin
      next_st.user_eff = next_st.user;
    end else begin
      next_st.user_eff = 8'h00;
    end
  end

  // Timer control; leaving for standby or reset forgets any delay progress.
  always_comb begin
    tmr_start = (st.mode == LDS_STANDBY) && (next_st.mode == LDS_STARTUP);
    tmr_clear = (next_st.mode == LDS_STANDBY) || (next_st.mode == LDS_RESET);
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st.mode <= LDS_RESET;
      st.ctrl <= `LDS_CTRL_RST;
      st.user <= `LDS_USER_RST;
      st.circ_en <= 1'b0;
      st.analog_en <= 1'b0;
      st.user_eff <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign mode_o = st.mode;
  assign circuits_en_o = st.circ_en;
  assign analog_en_o = st.analog_en;
  assign user_ctrl_o = st.user_eff;

  // Cycles spent since leaving standby, saturating; read only by checks.
  logic [AW-1:0] age;
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || st.mode == LDS_STANDBY || st.mode == LDS_RESET) begin
      age <= '0;
    end else if (age != AW'(STARTUP_CYCLES)) begin
      age <= age + AW'(1);
    end
  end

  // Quiet cycle: no reset cause is present.
  logic calm;
  assign calm = !por_i && !soft_rst;

  sequence s_startup_to_normal;
    st.mode == LDS_STARTUP ##1 st.mode == LDS_NORMAL;
  endsequence

  sequence s_cleared_defaults;
    st.mode == LDS_RESET && st.ctrl == `LDS_CTRL_RST && st.user == `LDS_USER_RST;
  endsequence

  property p_soft_reset;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    soft_rst && !por_i |=> s_cleared_defaults ##1 st.mode == LDS_STANDBY || $past(!calm);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_por_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    por_i [*2] |-> s_cleared_defaults and !circuits_en_o;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("registers not held during power-on reset");

  property p_reset_exit;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $fell(por_i) && calm && !wr_ok |=> st.mode == LDS_STANDBY && !run;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("no standby after reset release");

  property p_run_default;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_RESET |-> !run;
  endproperty
  a_run_default: assert property (p_run_default)
    else $error("run bit set in reset");

  property p_standby_cond;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode != LDS_RESET && (!run || !en_i) && calm |=> st.mode == LDS_STANDBY;
  endproperty
  a_standby_cond: assert property (p_standby_cond)
    else $error("not in standby with run or enable low");

  property p_standby_off;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_STANDBY |-> !circuits_en_o && !analog_en_o && user_ctrl_o == 8'h00;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("circuits active in standby");

  property p_write_gate;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_STANDBY && reg_if.wr_stb && !en_i && !por_i |=>
      $stable(st.ctrl) && $stable(st.user);
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write taken with enable pin low");

  property p_user_effect;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st.mode == LDS_NORMAL || st.mode == LDS_PSAVE) |-> user_ctrl_o == st.user;
  endproperty
  a_user_effect: assert property (p_user_effect)
    else $error("user controls not applied after startup");

  property p_startup_delay;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_startup_to_normal |-> age == AW'(STARTUP_CYCLES);
  endproperty
  a_startup_delay: assert property (p_startup_delay)
    else $error("normal entered before the startup delay");

  property p_overheat_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_STARTUP && overheat_shutdown_i && calm |=>
      (st.mode == LDS_STARTUP || st.mode == LDS_STANDBY) && !analog_en_o;
  endproperty
  a_overheat_hold: assert property (p_overheat_hold)
    else $error("left startup during overheat");

  property p_en_clears_run;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_NORMAL && !en_i && calm |=> !run && st.mode == LDS_STANDBY;
  endproperty
  a_en_clears_run: assert property (p_en_clears_run)
    else $error("run bit kept after enable low");

  property p_psave_analog;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_PSAVE |-> !analog_en_o && circuits_en_o && $past(psave);
  endproperty
  a_psave_analog: assert property (p_psave_analog)
    else $error("analog active in power save");

  property p_bad_key;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    reg_if.wr_stb && en_i && !por_i && reg_if.wr_idx == `LDS_IDX_SOFT_RESET
      && reg_if.wr_data != `LDS_SOFT_RESET_KEY |=> $stable(st.user) && st.mode != LDS_RESET;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("non-key reset write changed state");

  property p_expiry_normal;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st.mode == LDS_STARTUP && tmr_done && !overheat_shutdown_i && run && en_i && calm
      |=> st.mode == LDS_NORMAL ##1 st.mode != LDS_STARTUP || $past(overheat_shutdown_i);
  endproperty
  a_expiry_normal: assert property (p_expiry_normal)
    else $error("startup expiry did not enter normal");
endmodule : lds_mode_seq
`default_nettype wire

// [verilog/lds_map.svh]
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH
// Register indices; the byte address on the bus is four times the index.
`define LDS_IDX_CTRL 6'h00
`define LDS_IDX_USER 6'h01
`define LDS_IDX_STATUS 6'h02
`define LDS_IDX_SOFT_RESET 6'h0D
// Value that triggers the software reset.
`define LDS_SOFT_RESET_KEY 8'hFF
// Control register fields.
`define LDS_CTRL_RUN_BIT 0
`define LDS_CTRL_PSAVE_BIT 1
// Status register fields.
`define LDS_STAT_MODE_LSB 0
`define LDS_STAT_DONE_BIT 3
`define LDS_STAT_HOT_BIT 4
`define LDS_STAT_EN_BIT 5
// Reset values.
`define LDS_CTRL_RST 8'h00
`define LDS_USER_RST 8'h00
// Startup delay in microseconds and clock rate in MHz.
`define LDS_STARTUP_US 500
`define LDS_CLK_MHZ 100
`endif

// [verilog/lds_pkg.sv]
`default_nettype none
package lds_pkg;
  // Operating modes, Gray coded along reset, standby, startup, normal, power save.
  typedef enum logic [2:0] {
    LDS_RESET = 3'h0,
    LDS_STANDBY = 3'h1,
    LDS_STARTUP = 3'h3,
    LDS_NORMAL = 3'h2,
    LDS_PSAVE = 3'h6
  } lds_mode_t;
  // State of the mode sequencer.
  typedef struct packed {
    lds_mode_t mode;
    logic [7:0] ctrl;
    logic [7:0] user;
    logic circ_en;
    logic analog_en;
    logic [7:0] user_eff;
  } lds_seq_st_t;
  // State of the bus slave.
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } lds_bus_st_t;
endpackage : lds_pkg
`default_nettype wire

// [verilog/lds_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Register access strobes between the bus slave and the register file.
interface lds_reg_if;
  logic wr_stb;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  modport bus (output wr_stb, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_stb, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : lds_reg_if
`default_nettype wire

// [verilog/lds_avmm_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// Avalon-MM slave with exactly one wait cycle on every access.
module lds_avmm_slave
  import lds_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave port.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Register side.
  lds_reg_if.bus reg_if
);
  lds_bus_st_t st; // Registered state.
  lds_bus_st_t next_st; // Next state.
  logic req; // Any access pending.

  // The wait cycle lets read data come from a flop at the sampling edge.
  always_comb begin
    req = avs_read_i | avs_write_i;
    next_st = st;
    next_st.ack = req & ~st.ack;
    if (avs_read_i && !st.ack) begin
      next_st.rdata = reg_if.rd_data;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Only the low byte lane carries register data.
  assign avs_waitrequest_o = req & ~st.ack;
  assign avs_readdata_o = {24'h000000, st.rdata};
  assign reg_if.wr_stb = avs_write_i & st.ack & avs_byteenable_i[0];
  assign reg_if.wr_idx = avs_address_i[7:2];
  assign reg_if.wr_data = avs_writedata_i[7:0];
  assign reg_if.rd_idx = avs_address_i[7:2];
endmodule : lds_avmm_slave
`default_nettype wire

// [verilog/lds_delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// One-shot delay: done rises CYCLES edges after the start edge and stays up.
module lds_delay_timer #(
  parameter int CYCLES = 50000
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Control.
  input wire logic start_i,
  input wire logic clear_i,
  // Status.
  output logic done_o
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } lds_tmr_st_t;
  lds_tmr_st_t st; // Registered state.
  lds_tmr_st_t next_st; // Next state.

  // A count of one or less cannot be served by the reload scheme.
  if (CYCLES < 2) begin : g_bad_cycles
    $error("CYCLES must be at least 2");
  end

  // Clear wins over start so a leaving sequence never leaves a stale done.
  always_comb begin
    next_st = st;
    if (clear_i) begin
      next_st = '0;
    end else if (start_i) begin
      next_st.cnt = CW'(CYCLES - 1);
      next_st.busy = 1'b1;
      next_st.done = 1'b0;
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - CW'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
endmodule : lds_delay_timer
`default_nettype wire

// [tb/lds_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Behavioural host that issues Avalon-MM cycles on behalf of the bench.
module lds_host_model (
  // Clock.
  input wire logic sys_clk_i,
  // Avalon-MM master side.
  output logic [7:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  // The bus starts idle so that nothing is requested during reset.
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h00000000;
    avs_byteenable_o = 4'hF;
  end

  // One access, held until the rising edge at which waitrequest is seen low.
  task automatic access(input logic is_wr, input logic [5:0] idx, input logic [7:0] data,
                        output logic [31:0] rdata);
    rdata = 32'h00000000;
    @(posedge sys_clk_i);
    avs_address_o <= {idx, 2'b00};
    avs_read_o <= !is_wr;
    avs_write_o <= is_wr;
    avs_writedata_o <= {24'h000000, data};
    // Values read at the edge are those the slave saw there; read data is taken
    // at the same edge. Only the bench watchdog ends a wait that never finishes.
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_i !== 1'b0);
    rdata = avs_readdata_i;
    // Released lines show the inverse of the last value, so stale data cannot pass.
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_address_o <= ~{idx, 2'b00};
    avs_writedata_o <= ~{24'h000000, data};
  endtask : access
endmodule : lds_host_model
`default_nettype wire

// [tb/lds_mode_seq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lds_map.svh"
module lds_mode_seq_tb;
  import lds_pkg::*;
  // Short startup count keeps the run brief.
  localparam int STARTUP_CYCLES = 20;
  logic sys_clk_i, resetn_i, por_i, en_i, overheat_shutdown_i;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [2:0] mode_o;
  logic circuits_en_o, analog_en_o;
  logic [7:0] user_ctrl_o;
  int errors = 0;
  int n_compared = 0;

  // Clock at 100 MHz.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  lds_mode_seq #(.STARTUP_CYCLES(STARTUP_CYCLES)) dut (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .por_i(por_i), .en_i(en_i),
    .overheat_shutdown_i(overheat_shutdown_i), .mode_o(mode_o),
    .circuits_en_o(circuits_en_o), .analog_en_o(analog_en_o), .user_ctrl_o(user_ctrl_o));

  lds_host_model host (.sys_clk_i(sys_clk_i), .avs_address_o(avs_address),
    .avs_read_o(avs_read), .avs_write_o(avs_write), .avs_writedata_o(avs_writedata),
    .avs_byteenable_o(avs_byteenable), .avs_readdata_i(avs_readdata),
    .avs_waitrequest_i(avs_waitrequest));

  // Compare tasks, one per kind of result.
  task automatic chk_mode(input lds_mode_t exp);
    n_compared++;
    if (mode_o !== exp) begin
      errors++;
      $display("mismatch at %0t: mode %h expected %h", $time, mode_o, exp);
    end
  endtask : chk_mode
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s is %h expected %h", $time, what, got, exp);
    end
  endtask : chk_data
  task automatic chk_outs(input logic circ, input logic ana, input logic [7:0] usr);
    chk_data({31'h0, circuits_en_o}, {31'h0, circ}, "circuit enable");
    chk_data({31'h0, analog_en_o}, {31'h0, ana}, "analog enable");
    chk_data({24'h0, user_ctrl_o}, {24'h0, usr}, "user control");
  endtask : chk_outs

  // Bus helpers.
  task automatic wr(input logic [5:0] idx, input logic [7:0] data);
    logic [31:0] r;
    host.access(1'b1, idx, data, r);
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    host.access(1'b0, idx, 8'h00, r);
    chk_data(r, {24'h000000, exp}, "read data");
  endtask : rd
  // Waits a bounded number of cycles for a mode, then compares.
  task automatic wait_mode(input lds_mode_t exp, input int max);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (mode_o !== exp && n < max);
    chk_mode(exp);
  endtask : wait_mode

  // Power-on indication holds defaults, release leads to standby.
  task automatic t_reset();
    @(negedge sys_clk_i);
    chk_mode(LDS_RESET);
    chk_outs(1'b0, 1'b0, 8'h00);
    @(posedge sys_clk_i);
    por_i <= 1'b0;
    wait_mode(LDS_STANDBY, 3);
    chk_outs(1'b0, 1'b0, 8'h00);
    rd(`LDS_IDX_CTRL, 8'h00);
  endtask : t_reset

  // Timed startup; stored user byte only acts once it completes.
  task automatic t_startup();
    int n;
    wr(`LDS_IDX_USER, 8'h5A);
    repeat (3) @(negedge sys_clk_i);
    chk_mode(LDS_STANDBY);
    chk_outs(1'b0, 1'b0, 8'h00);
    wr(`LDS_IDX_CTRL, 8'h01);
    wait_mode(LDS_STARTUP, 4);
    n = 0;
    while (mode_o !== LDS_NORMAL && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk_data(n, STARTUP_CYCLES + 1, "startup cycles");
    chk_outs(1'b1, 1'b1, 8'h5A);
    rd(`LDS_IDX_STATUS, 8'h2A);
  endtask : t_startup

  // Power save drops analog only and keeps digital state.
  task automatic t_psave();
    wr(`LDS_IDX_CTRL, 8'h03);
    wait_mode(LDS_PSAVE, 4);
    chk_outs(1'b1, 1'b0, 8'h5A);
    wr(`LDS_IDX_CTRL, 8'h01);
    wait_mode(LDS_NORMAL, 4);
  endtask : t_psave

  // Overheat holds startup well past the timer, then normal resumes.
  task automatic t_overheat();
    @(posedge sys_clk_i);
    overheat_shutdown_i <= 1'b1;
    wait_mode(LDS_STARTUP, 4);
    repeat (STARTUP_CYCLES + 10) @(negedge sys_clk_i);
    chk_mode(LDS_STARTUP);
    chk_data({31'h0, analog_en_o}, 32'h0, "analog enable");
    rd(`LDS_IDX_STATUS, 8'h3B);
    @(posedge sys_clk_i);
    overheat_shutdown_i <= 1'b0;
    wait_mode(LDS_NORMAL, 3);
  endtask : t_overheat

  // Enable low clears run; writes meanwhile are ignored.
  task automatic t_en_low();
    @(posedge sys_clk_i);
    en_i <= 1'b0;
    wait_mode(LDS_STANDBY, 3);
    chk_outs(1'b0, 1'b0, 8'h00);
    wr(`LDS_IDX_USER, 8'h11);
    @(posedge sys_clk_i);
    en_i <= 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk_mode(LDS_STANDBY);
    rd(`LDS_IDX_CTRL, 8'h00);
    rd(`LDS_IDX_USER, 8'h5A);
  endtask : t_en_low

  // Soft reset only on the key value; other addresses read zero.
  task automatic t_soft();
    wr(`LDS_IDX_SOFT_RESET, 8'h12);
    rd(`LDS_IDX_USER, 8'h5A);
    wr(`LDS_IDX_CTRL, 8'h04);
    wr(`LDS_IDX_SOFT_RESET, `LDS_SOFT_RESET_KEY);
    wait_mode(LDS_RESET, 3);
    wait_mode(LDS_STANDBY, 3);
    rd(`LDS_IDX_CTRL, 8'h00);
    rd(`LDS_IDX_USER, 8'h00);
    rd(`LDS_IDX_SOFT_RESET, 8'h00);
    rd(6'h3F, 8'h00);
  endtask : t_soft

  // Supply dip in normal mode returns everything to defaults.
  task automatic t_por();
    wr(`LDS_IDX_USER, 8'hC3);
    wr(`LDS_IDX_CTRL, 8'h01);
    wait_mode(LDS_NORMAL, STARTUP_CYCLES + 8);
    @(posedge sys_clk_i);
    por_i <= 1'b1;
    wait_mode(LDS_RESET, 3);
    @(negedge sys_clk_i);
    chk_outs(1'b0, 1'b0, 8'h00);
    @(posedge sys_clk_i);
    por_i <= 1'b0;
    wait_mode(LDS_STANDBY, 3);
    rd(`LDS_IDX_CTRL, 8'h00);
    rd(`LDS_IDX_USER, 8'h00);
  endtask : t_por

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Main sequence; reset held for two cycles with the supply indication up.
  initial begin
    resetn_i = 1'b0;
    por_i = 1'b1;
    en_i = 1'b1;
    overheat_shutdown_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_startup();
    t_psave();
    t_overheat();
    t_en_low();
    t_soft();
    t_por();
    final_report();
  end

  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule : lds_mode_seq_tb
`default_nettype wire
